// ---- logic/line_serdes_cfg.sv ----
// APB register bank configuring one channel's line-side serdes PLL, TX and RX
//
// Added by the designer: the APB slave port.
`include "line_serdes_regs.svh"

//------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------
// Overview of operation
// - PLL config word at index 0x02, resets 0x811D, reserved top bits 100000.
// - Loop bandwidth bits 9:8 reset 01; 01 no cleaner, 10 cleaner.
// - VCO range bit 6 resets 0 (high end); 1 selects low end.
// - PLL enable bit 4 resets 1; pin low or global power-down forces off.
// - Multiplier bits 3:0 reset 1101; codes 2..7 give 4,5,6,8,8.25,10.
// - Codes 8..14 give 12,12.5,15,16,16.5,20,25; code 15 reserved.
// - TX/RX config word at index 0x03, resets 0xA444.
// - Swing code bits 15:12 reset 1010, driven to transmit driver.
// - TX enable bit 10 resets 1; pin low or global power-down forces off.
// - TX rate bits 9:8 reset 00; full, half, quarter, eighth.
// - Gain mode bits 7:6 reset 01; freeze-first, freeze-locked, off, on.
// - Auto-zero bits 5:4 reset 00; on-enable, off, forced update, forced hold.
// - Unscrambled bit 3 resets 0; advised 0 at full, 1 otherwise.
// - RX enable bit 2 resets 1; pin low or global power-down forces off.
// - RX rate bits 1:0 reset 00; full, half, quarter, eighth.
module line_serdes_cfg
   import line_serdes_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // Clock, reset and freeze
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,

   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,

   // Channel power-down pin, low powers the channel down
   input  wire logic              channel_powerdown_n,

   // PLL controls
   output loop_bw_t               pll_loop_bw_sel,
   output logic                   vco_low_range,
   output logic                   pll_enable,
   output logic      [3:0]        pll_multiplier_code,
   output logic      [6:0]        pll_mult_quarters,

   // Transmitter controls
   output logic      [3:0]        tx_output_swing_code,
   output logic                   tx_enable,
   output line_rate_t             tx_rate_sel,
   output logic      [3:0]        tx_rate_div,

   // Receiver controls
   output agc_mode_t              gain_control_mode,
   output azcal_mode_t            auto_zero_cal_mode,
   output logic                   unscrambled_data_use,
   output logic                   rx_enable,
   output line_rate_t             rx_rate_sel,
   output logic      [3:0]        rx_rate_div
);

   //---------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------

   cfg_word_t   pll_word;
   cfg_word_t   txrx_word;
   logic        global_pd;
   logic        pin_up;
   logic        power_ok;
   logic [7:0]  status_bits;

   logic        setup;
   logic        access;
   logic        wr_pll;
   logic        wr_txrx;
   logic        wr_global;

   logic        hit_pll;
   logic        hit_txrx;
   logic        hit_global;
   logic        hit_status;
   logic        hit_any;

   logic [31:0] next_prdata;
   logic [6:0]  next_quarters;
   logic        mult_reserved;
   logic        bw_reserved;
   logic        unscr_odd;

   //---------------------------------------------------------------
   // Multiplier decode
   //---------------------------------------------------------------

   // Factor in quarter steps so 8.25x and 16.5x stay exact
   function automatic logic [6:0] mult_to_quarters(input logic [3:0] code);
      logic [6:0] q;
      q = 7'h00;
      unique case (code)
         4'h2:    q = 7'h10;
         4'h3:    q = 7'h14;
         4'h4:    q = 7'h18;
         4'h5:    q = 7'h20;
         4'h6:    q = 7'h21;
         4'h7:    q = 7'h28;
         4'h8:    q = 7'h30;
         4'h9:    q = 7'h32;
         4'hA:    q = 7'h3C;
         4'hB:    q = 7'h40;
         4'hC:    q = 7'h42;
         4'hD:    q = 7'h50;
         4'hE:    q = 7'h64;
         default: q = 7'h00;
      endcase
      return q;
   endfunction

   //---------------------------------------------------------------
   // Pin synchroniser
   //---------------------------------------------------------------

   // Pin is asynchronous; held low-safe so enables start off
   pin_sync #(
      .RESET (`PIN_SYNC_RST)
   ) u_pd_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .pin     (channel_powerdown_n),
      .level   (pin_up)
   );

   //---------------------------------------------------------------
   // Bus decode
   //---------------------------------------------------------------

   // Setup phase starts an answer, access phase completes it
   assign setup  = psel && !penable;
   assign access = psel && penable && pready;

   // Word index decode; low address bits are ignored
   assign hit_global = paddr[ADDR_W-1:2] == (ADDR_W-2)'(`GLOBAL_CTRL_IDX);
   assign hit_pll    = paddr[ADDR_W-1:2] == (ADDR_W-2)'(`LINE_PLL_CONFIG_IDX);
   assign hit_txrx   = paddr[ADDR_W-1:2] == (ADDR_W-2)'(`LINE_TXRX_CONFIG_IDX);
   assign hit_status = paddr[ADDR_W-1:2] == (ADDR_W-2)'(`CHANNEL_STATUS_IDX);
   assign hit_any    = hit_global || hit_pll || hit_txrx || hit_status;

   // Writes land only at the completing edge
   assign wr_pll    = access && pwrite && hit_pll;
   assign wr_txrx   = access && pwrite && hit_txrx;
   assign wr_global = access && pwrite && hit_global;

   //---------------------------------------------------------------
   // Configuration storage
   //---------------------------------------------------------------

   // PLL word; reset carries the reserved 100000 pattern
   cfg_word #(
      .WIDTH (16),
      .RESET (`LINE_PLL_CONFIG_RST)
   ) u_pll_word (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .wr_en   (wr_pll),
      .byte_en (pstrb[1:0]),
      .wr_data (pwdata[15:0]),
      .q       (pll_word)
   );

   // Transmit/receive word
   cfg_word #(
      .WIDTH (16),
      .RESET (`LINE_TXRX_CONFIG_RST)
   ) u_txrx_word (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .wr_en   (wr_txrx),
      .byte_en (pstrb[1:0]),
      .wr_data (pwdata[15:0]),
      .q       (txrx_word)
   );

   // Global power-down bit, lives in the upper byte lane
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_pd <= `GLOBAL_CTRL_RST;
      end else if (clk_en && wr_global && pstrb[1]) begin
         global_pd <= pwdata[`GLOBAL_PD_BIT];
      end
   end

   //---------------------------------------------------------------
   // Power gating and field decode
   //---------------------------------------------------------------

   // Either power-down source forces every enable off
   assign power_ok = pin_up && !global_pd;

   assign next_quarters = mult_to_quarters(pll_word[`PLL_MULT_HI:`PLL_MULT_LO]);
   assign mult_reserved = next_quarters == 7'h00;
   assign bw_reserved   = pll_word[`PLL_BW_HI] == pll_word[`PLL_BW_LO];

   // Unscrambled use differs from the advised setting for the RX rate
   assign unscr_odd = txrx_word[`UNSCR_BIT] !=
                      (txrx_word[`RX_RATE_HI:`RX_RATE_LO] != rate_full);

   //---------------------------------------------------------------
   // PLL outputs
   //---------------------------------------------------------------

   // Registered one cycle after storage so outputs come from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_loop_bw_sel     <= bw_no_cleaner;
         vco_low_range       <= 1'b0;
         pll_enable          <= 1'b0;
         pll_multiplier_code <= 4'h0;
         pll_mult_quarters   <= 7'h00;
      end else if (clk_en) begin
         pll_loop_bw_sel     <= loop_bw_t'(pll_word[`PLL_BW_HI:`PLL_BW_LO]);
         vco_low_range       <= pll_word[`VCO_RANGE_BIT];
         pll_enable          <= pll_word[`PLL_EN_BIT] && power_ok;
         pll_multiplier_code <= pll_word[`PLL_MULT_HI:`PLL_MULT_LO];
         pll_mult_quarters   <= next_quarters;
      end
   end

   //---------------------------------------------------------------
   // Transmitter outputs
   //---------------------------------------------------------------

   // Rate code becomes a divide ratio of 1, 2, 4 or 8
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_output_swing_code <= 4'h0;
         tx_enable            <= 1'b0;
         tx_rate_sel          <= rate_full;
         tx_rate_div          <= 4'h1;
      end else if (clk_en) begin
         tx_output_swing_code <= txrx_word[`SWING_HI:`SWING_LO];
         tx_enable            <= txrx_word[`TX_EN_BIT] && power_ok;
         tx_rate_sel          <= line_rate_t'(txrx_word[`TX_RATE_HI:`TX_RATE_LO]);
         tx_rate_div          <= 4'h1 << txrx_word[`TX_RATE_HI:`TX_RATE_LO];
      end
   end

   //---------------------------------------------------------------
   // Receiver outputs
   //---------------------------------------------------------------

   // Gain and calibration modes pass through unchanged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gain_control_mode    <= agc_freeze_lock;
         auto_zero_cal_mode   <= azcal_on_enable;
         unscrambled_data_use <= 1'b0;
         rx_enable            <= 1'b0;
         rx_rate_sel          <= rate_full;
         rx_rate_div          <= 4'h1;
      end else if (clk_en) begin
         gain_control_mode    <= agc_mode_t'(txrx_word[`AGC_HI:`AGC_LO]);
         auto_zero_cal_mode   <= azcal_mode_t'(txrx_word[`AZCAL_HI:`AZCAL_LO]);
         unscrambled_data_use <= txrx_word[`UNSCR_BIT];
         rx_enable            <= txrx_word[`RX_EN_BIT] && power_ok;
         rx_rate_sel          <= line_rate_t'(txrx_word[`RX_RATE_HI:`RX_RATE_LO]);
         rx_rate_div          <= 4'h1 << txrx_word[`RX_RATE_HI:`RX_RATE_LO];
      end
   end

   //---------------------------------------------------------------
   // Status word
   //---------------------------------------------------------------

   // Live view of gated enables, power sources and odd settings
   always_comb begin
      status_bits                     = 8'h00;
      status_bits[`ST_PLL_ON_BIT]     = pll_enable;
      status_bits[`ST_TX_ON_BIT]      = tx_enable;
      status_bits[`ST_RX_ON_BIT]      = rx_enable;
      status_bits[`ST_PIN_UP_BIT]     = pin_up;
      status_bits[`ST_GLOBAL_PD_BIT]  = global_pd;
      status_bits[`ST_MULT_RSVD_BIT]  = mult_reserved;
      status_bits[`ST_BW_RSVD_BIT]    = bw_reserved;
      status_bits[`ST_UNSCR_ODD_BIT]  = unscr_odd;
   end

   //---------------------------------------------------------------
   // Read mux
   //---------------------------------------------------------------

   // Stored words read back whole, reserved bits included
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit_pll) begin
         next_prdata[15:0] = pll_word;
      end else if (hit_txrx) begin
         next_prdata[15:0] = txrx_word;
      end else if (hit_global) begin
         next_prdata[`GLOBAL_PD_BIT] = global_pd;
      end else if (hit_status) begin
         next_prdata[7:0] = status_bits;
      end
   end

   //---------------------------------------------------------------
   // APB answer
   //---------------------------------------------------------------

   // One wait-free access phase; data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else if (clk_en) begin
         pready <= setup;
      end
   end

   // Read data held through the access phase, cleared after
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en) begin
         if (setup && !pwrite) begin
            prdata <= next_prdata;
         end else if (access) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Unmapped words answer with an error; status is read-only too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (clk_en) begin
         if (setup) begin
            pslverr <= !hit_any || (pwrite && hit_status);
         end else if (access) begin
            pslverr <= 1'b0;
         end
      end
   end

endmodule

// ---- logic/line_serdes_regs.svh ----
// Register indices, field positions and reset values of the line serdes bank
`ifndef LINE_SERDES_REGS_SVH
`define LINE_SERDES_REGS_SVH

// Register indices; the byte address is four times the index
`define GLOBAL_CTRL_IDX      10'h001
`define LINE_PLL_CONFIG_IDX  10'h002
`define LINE_TXRX_CONFIG_IDX 10'h003
`define CHANNEL_STATUS_IDX   10'h007

// Reset values
`define LINE_PLL_CONFIG_RST  16'h811D
`define LINE_TXRX_CONFIG_RST 16'hA444
`define GLOBAL_CTRL_RST      1'b0
`define PIN_SYNC_RST         1'b0

// Global control fields
`define GLOBAL_PD_BIT        15

// PLL configuration fields
`define PLL_BW_HI            9
`define PLL_BW_LO            8
`define VCO_RANGE_BIT        6
`define PLL_EN_BIT           4
`define PLL_MULT_HI          3
`define PLL_MULT_LO          0

// Transmit/receive configuration fields
`define SWING_HI             15
`define SWING_LO             12
`define TX_EN_BIT            10
`define TX_RATE_HI           9
`define TX_RATE_LO           8
`define AGC_HI               7
`define AGC_LO               6
`define AZCAL_HI             5
`define AZCAL_LO             4
`define UNSCR_BIT            3
`define RX_EN_BIT            2
`define RX_RATE_HI           1
`define RX_RATE_LO           0

// Channel status fields
`define ST_PLL_ON_BIT        0
`define ST_TX_ON_BIT         1
`define ST_RX_ON_BIT         2
`define ST_PIN_UP_BIT        3
`define ST_GLOBAL_PD_BIT     4
`define ST_MULT_RSVD_BIT     5
`define ST_BW_RSVD_BIT       6
`define ST_UNSCR_ODD_BIT     7

`endif

// ---- logic/line_serdes_pkg.sv ----
// Types shared by the line serdes configuration bank
package line_serdes_pkg;

   typedef logic [15:0] cfg_word_t;

   typedef enum logic [1:0] {
      bw_reserved_lo = 2'h0,
      bw_no_cleaner  = 2'h1,
      bw_cleaner     = 2'h2,
      bw_reserved_hi = 2'h3
   } loop_bw_t;

   typedef enum logic [1:0] {
      rate_full    = 2'h0,
      rate_half    = 2'h1,
      rate_quarter = 2'h2,
      rate_eighth  = 2'h3
   } line_rate_t;

   typedef enum logic [1:0] {
      agc_freeze_first = 2'h0,
      agc_freeze_lock  = 2'h1,
      agc_force_off    = 2'h2,
      agc_force_on     = 2'h3
   } agc_mode_t;

   typedef enum logic [1:0] {
      azcal_on_enable  = 2'h0,
      azcal_off        = 2'h1,
      azcal_force_upd  = 2'h2,
      azcal_force_hold = 2'h3
   } azcal_mode_t;

endpackage

// ---- logic/pin_sync.sv ----
// Two flip-flop synchroniser for one asynchronous pin
module pin_sync #(
   parameter logic RESET = 1'b0
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic clk_en,
   // Pin and synchronised level
   input  wire logic pin,
   output logic      level
);

   logic meta;

   // First stage is read only by the second stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta  <= RESET;
         level <= RESET;
      end else if (clk_en) begin
         meta  <= pin;
         level <= meta;
      end
   end

endmodule

// ---- logic/cfg_word.sv ----
// One read-write configuration word with byte lane enables
module cfg_word #(
   parameter int            WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET = '0
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             clk_en,
   // Write port
   input  wire logic             wr_en,
   input  wire logic [WIDTH/8-1:0] byte_en,
   input  wire logic [WIDTH-1:0] wr_data,
   // Stored value
   output logic      [WIDTH-1:0] q
);

   // Every bit is plain storage, reserved ones included
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= RESET;
      end else if (clk_en && wr_en) begin
         for (int i = 0; i < WIDTH / 8; i++) begin
            if (byte_en[i]) begin
               q[i*8 +: 8] <= wr_data[i*8 +: 8];
            end
         end
      end
   end

endmodule

// ---- verification/line_serdes_cfg_checker.sv ----
// Port-level assertions for the line serdes configuration bank
module line_serdes_cfg_checker
   import line_serdes_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic              pready,
   input wire logic              pslverr,
   // Pin and controls
   input wire logic              channel_powerdown_n,
   input wire loop_bw_t          pll_loop_bw_sel,
   input wire logic              pll_enable,
   input wire logic [3:0]        pll_multiplier_code,
   input wire logic [3:0]        tx_output_swing_code,
   input wire logic              tx_enable,
   input wire line_rate_t        tx_rate_sel,
   input wire logic [3:0]        tx_rate_div,
   input wire logic              rx_enable,
   input wire line_rate_t        rx_rate_sel
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   //------------------------------------------------------------------
   // Full-word writes; outputs follow two edges after the access edge
   //------------------------------------------------------------------
   logic wr_pll;
   logic wr_txrx;
   assign wr_pll = psel & penable & pready & pwrite & (pstrb == 4'h3) & (paddr == 12'h008);
   assign wr_txrx = psel & penable & pready & pwrite & (pstrb == 4'h3) & (paddr == 12'h00C);

   a_bw_follows_wr: assert property (
      wr_pll |=> ##1 pll_loop_bw_sel == $past(pwdata[9:8], 2)) else $error("loop bw wrong");
   a_mult_follows_wr: assert property (
      wr_pll |=> ##1 pll_multiplier_code == $past(pwdata[3:0], 2)) else $error("mult wrong");
   a_swing_follows_wr: assert property (
      wr_txrx |=> ##1 tx_output_swing_code == $past(pwdata[15:12], 2)) else $error("swing wrong");
   a_txrate_follows_wr: assert property (
      wr_txrx |=> ##1 tx_rate_sel == $past(pwdata[9:8], 2)) else $error("tx rate wrong");
   a_rxrate_follows_wr: assert property (
      wr_txrx |=> ##1 rx_rate_sel == $past(pwdata[1:0], 2)) else $error("rx rate wrong");
   a_txdiv_decode: assert property (
      tx_rate_div == (4'h1 << tx_rate_sel)) else $error("tx divider wrong");

   // Pin low for three edges must have reached every enable
   a_pll_pin_gate: assert property (
      (!channel_powerdown_n) [*3] |=> !pll_enable) else $error("pll on while pin low");
   a_tx_pin_gate: assert property (
      (!channel_powerdown_n) [*3] |=> !tx_enable) else $error("tx on while pin low");
   a_rx_pin_gate: assert property (
      (!channel_powerdown_n) [*3] |=> !rx_enable) else $error("rx on while pin low");

   c_pll_write: cover property (wr_pll);
   c_txrx_write: cover property (wr_txrx);
   c_pin_down: cover property ((!channel_powerdown_n) [*3]);
   c_bus_error: cover property (pslverr && pready);
endmodule

bind line_serdes_cfg line_serdes_cfg_checker #(.ADDR_W(ADDR_W)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
   .channel_powerdown_n(channel_powerdown_n), .pll_loop_bw_sel(pll_loop_bw_sel),
   .pll_enable(pll_enable), .pll_multiplier_code(pll_multiplier_code),
   .tx_output_swing_code(tx_output_swing_code), .tx_enable(tx_enable),
   .tx_rate_sel(tx_rate_sel), .tx_rate_div(tx_rate_div), .rx_enable(rx_enable),
   .rx_rate_sel(rx_rate_sel));

// ---- verification/line_serdes_cfg_test.sv ----
// Self-checking bench for the line serdes configuration bank
`include "line_serdes_regs.svh"

module line_serdes_cfg_test;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [11:0] PLL_A  = {`LINE_PLL_CONFIG_IDX, 2'b00};
   localparam logic [11:0] TXRX_A = {`LINE_TXRX_CONFIG_IDX, 2'b00};
   localparam logic [11:0] GLB_A  = {`GLOBAL_CTRL_IDX, 2'b00};

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        clk_en = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic        pin_n = 1'b1;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err;
   logic [1:0]  bw, txr, rxr, agc, azc;
   logic        vco, pen, ten, ren, unscr;
   logic [3:0]  mult, swing, txd, rxd;
   logic [6:0]  quarters;
   logic [6:0]  qtab [16] = '{7'h00, 7'h00, 7'h10, 7'h14, 7'h18, 7'h20, 7'h21, 7'h28,
                              7'h30, 7'h32, 7'h3C, 7'h40, 7'h42, 7'h50, 7'h64, 7'h00};
   logic [3:0]  c;
   logic [1:0]  k;
   logic [3:0]  sw;
   int          n_errors = 0;
   int          compares = 0;
   wire  [14:0] pll_out = {bw, vco, pen, mult, quarters};
   wire  [22:0] txrx_out = {swing, ten, txr, agc, azc, unscr, ren, rxr, txd, rxd};

   line_serdes_cfg dut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .channel_powerdown_n(pin_n),
      .pll_loop_bw_sel(bw), .vco_low_range(vco), .pll_enable(pen),
      .pll_multiplier_code(mult), .pll_mult_quarters(quarters),
      .tx_output_swing_code(swing), .tx_enable(ten), .tx_rate_sel(txr), .tx_rate_div(txd),
      .gain_control_mode(agc), .auto_zero_cal_mode(azc), .unscrambled_data_use(unscr),
      .rx_enable(ren), .rx_rate_sel(rxr), .rx_rate_div(rxd));

   //------------------------------------------------------------------
   // Clock, comparison and report
   //------------------------------------------------------------------
   initial begin
      forever #50 pclk = ~pclk;
   end

   task automatic summarize;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      // Answer and data are taken at the edge that sees pready high
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_errors++;
         $display("ERROR pready expected 1 seen timeout");
         summarize();
      end
   endtask

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'h0);
      check(what, exp, rd);
      check("pslverr", 32'h0, err);
   endtask

   // Decoded and gated outputs lag the storing edge
   task automatic settle(input int n);
      repeat (n) @(negedge pclk);
   endtask

   //------------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      settle(6);
      rdchk("pll reset", PLL_A, 32'h0000811D);
      rdchk("txrx reset", TXRX_A, 32'h0000A444);
      check("pll outputs", {2'b01, 1'b0, 1'b1, 4'hD, 7'h50}, pll_out);
      check("txrx outputs", 23'h54_4411, txrx_out);
      // Every multiplier and bandwidth code, reserved ones stored as written
      for (int i = 0; i < 16; i++) begin
         c = i[3:0];
         apb(1'b1, PLL_A, {16'h0, 6'h20, c[1:0], 4'h5, c}, 4'h3);
         settle(3);
         check("pll out", {c[1:0], 1'b1, 1'b1, c, qtab[i]}, pll_out);
         rdchk("pll back", PLL_A, {16'h0, 6'h20, c[1:0], 4'h5, c});
      end
      // Rates, gain, auto-zero and swing codes
      for (int i = 0; i < 4; i++) begin
         k = i[1:0];
         sw = {k, ~k};
         // Unscrambled use follows the advice for the receive rate
         apb(1'b1, TXRX_A, {16'h0, sw, 2'b01, k, k, k, k != 2'h3, 1'b1, ~k}, 4'h3);
         settle(3);
         check("txrx out", {sw, 1'b1, k, k, k, k != 2'h3, 1'b1, ~k, 4'h1 << k, 4'h1 << ~k},
               txrx_out);
         rdchk("txrx back", TXRX_A, {16'h0, sw, 2'b01, k, k, k, k != 2'h3, 1'b1, ~k});
      end
      apb(1'b1, PLL_A, 32'h0, 4'h2);
      rdchk("lane write", PLL_A, 32'h0000005F);
      // Pin and global power-down gate outputs only
      @(posedge pclk);
      pin_n <= 1'b0;
      settle(6);
      check("pin down", 3'b000, {pen, ten, ren});
      rdchk("stored kept", TXRX_A, 32'h0000C7F4);
      @(posedge pclk);
      pin_n <= 1'b1;
      settle(6);
      check("pin up", 3'b111, {pen, ten, ren});
      apb(1'b1, GLB_A, 32'h00008000, 4'h3);
      settle(6);
      check("global down", 3'b000, {pen, ten, ren});
      rdchk("global back", GLB_A, 32'h00008000);
      apb(1'b1, GLB_A, 32'h0, 4'h3);
      settle(6);
      check("global up", 3'b111, {pen, ten, ren});
      // Unmapped place answers with an error and no data
      apb(1'b0, 12'h3FC, 32'h0, 4'h0);
      check("unmapped data", 32'h0, rd);
      check("unmapped err", 32'h1, err);
      // Status: enables on, pin up, reserved multiplier and bandwidth codes flagged
      rdchk("status", {`CHANNEL_STATUS_IDX, 2'b00}, 32'h0000006F);
      apb(1'b1, {`CHANNEL_STATUS_IDX, 2'b00}, 32'h0, 4'h3);
      check("status write err", 32'h1, err);
      summarize();
   end
endmodule
